// ---- rtl/fcim_mux_ctrl.sv ----
`timescale 1ns/1ps
// How it works
// - upstream pair routed to one channel or none
// - at most one channel, chosen by stored byte
// - four active-low per-channel interrupt inputs
// - interrupt output is AND of the inputs
// - reset clears registers, state machine, channels
// - three pins set low address bits
// - address last bit: 1 read, 0 write
// - data byte after write address is stored
// - several bytes: last complete byte kept
// - control byte readable over the bus
// - works at any clock up to 400 kHz
// - bit 2 enables, bits 1:0 pick channel
// - new channel connects only after stop
// - read bits 4-7 report channel interrupts 0-3
module fcim_mux_ctrl
    import fcim_pkg::*;
(
    // system clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // free-running link sampling clock
    input wire logic LINK_CLK,
    // address straps
    input wire logic ADDR_PIN_0,
    input wire logic ADDR_PIN_1,
    input wire logic ADDR_PIN_2,
    // upstream clock line
    input wire logic UP_CLK_IN,
    output logic UP_CLK_OUT,
    output logic UP_CLK_OE,
    // upstream data line
    input wire logic UP_DAT_IN,
    output logic UP_DAT_OUT,
    output logic UP_DAT_OE,
    // channel 0
    input wire logic DOWN_CLK_0_IN,
    output logic DOWN_CLK_0_OUT,
    output logic DOWN_CLK_0_OE,
    input wire logic DOWN_DAT_0_IN,
    output logic DOWN_DAT_0_OUT,
    output logic DOWN_DAT_0_OE,
    // channel 1
    input wire logic DOWN_CLK_1_IN,
    output logic DOWN_CLK_1_OUT,
    output logic DOWN_CLK_1_OE,
    input wire logic DOWN_DAT_1_IN,
    output logic DOWN_DAT_1_OUT,
    output logic DOWN_DAT_1_OE,
    // channel 2
    input wire logic DOWN_CLK_2_IN,
    output logic DOWN_CLK_2_OUT,
    output logic DOWN_CLK_2_OE,
    input wire logic DOWN_DAT_2_IN,
    output logic DOWN_DAT_2_OUT,
    output logic DOWN_DAT_2_OE,
    // channel 3
    input wire logic DOWN_CLK_3_IN,
    output logic DOWN_CLK_3_OUT,
    output logic DOWN_CLK_3_OE,
    input wire logic DOWN_DAT_3_IN,
    output logic DOWN_DAT_3_OUT,
    output logic DOWN_DAT_3_OE,
    // interrupts
    input wire logic IRQ_IN_N_0,
    input wire logic IRQ_IN_N_1,
    input wire logic IRQ_IN_N_2,
    input wire logic IRQ_IN_N_3,
    output logic IRQ_OUT_N
);

    // ---------------- link domain ----------------

    logic link_rst_meta; // reset release stage one
    logic link_rst_n; // reset for the link domain, released synchronously

    // asynchronous assert, synchronous release on the link clock
    always_ff @(posedge LINK_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            link_rst_meta <= 1'b0;
            link_rst_n <= 1'b0;
        end else begin
            link_rst_meta <= 1'b1;
            link_rst_n <= link_rst_meta;
        end
    end

    logic [1:0] bus_s; // synced {data, clock} in the link domain
    logic [2:0] pins_s; // synced address straps
    logic [3:0] irq_link_s; // synced interrupts, for the read byte

    fcim_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_bus_sync (
        .clk(LINK_CLK),
        .rst_n(link_rst_n),
        .d({UP_DAT_IN, UP_CLK_IN}),
        .q(bus_s)
    );

    fcim_sync #(.WIDTH(3), .RESET_VAL(3'h0)) u_pin_sync (
        .clk(LINK_CLK),
        .rst_n(link_rst_n),
        .d({ADDR_PIN_2, ADDR_PIN_1, ADDR_PIN_0}),
        .q(pins_s)
    );

    fcim_sync #(.WIDTH(4), .RESET_VAL(4'hf)) u_irq_link_sync (
        .clk(LINK_CLK),
        .rst_n(link_rst_n),
        .d({IRQ_IN_N_3, IRQ_IN_N_2, IRQ_IN_N_1, IRQ_IN_N_0}),
        .q(irq_link_s)
    );

    // link state; the machine only moves on bus edges, so a stopped clock is safe
    fcim_state_t state, next_state;
    logic [3:0] bitcnt, next_bitcnt; // bits seen in the current byte
    logic [7:0] shreg, next_shreg; // incoming byte
    logic [7:0] txreg, next_txreg; // outgoing byte, msb first
    logic [3:0] ctrl, next_ctrl; // stored control bits 3:0
    logic rw, next_rw; // direction of the current transfer
    logic nack, next_nack; // master declined more read data
    logic pend, next_pend; // written byte awaiting a stop
    logic tgt_drive, next_tgt_drive; // pull the upstream data low
    logic fire, next_fire; // one-cycle pulse: apply the byte
    logic scl_q, sda_q; // previous bus levels

    wire scl = bus_s[0];
    wire sda = bus_s[1];
    wire scl_rise = scl & ~scl_q;
    wire scl_fall = ~scl & scl_q;
    wire start_det = scl & scl_q & sda_q & ~sda;
    wire stop_det = scl & scl_q & ~sda_q & sda;
    wire [6:0] own_addr = {ADDR_FIXED, pins_s};
    wire addr_hit = (shreg[7:1] == own_addr);
    wire [7:0] read_byte = {~irq_link_s, ctrl};
    wire [3:0] sh_low = shreg[3:0];
    wire byte_done = (bitcnt == BITS_PER_BYTE);

    // next-state decode for the bus target
    always_comb begin
        next_state = state;
        next_bitcnt = bitcnt;
        next_shreg = shreg;
        next_txreg = txreg;
        next_ctrl = ctrl;
        next_rw = rw;
        next_nack = nack;
        next_pend = pend;
        next_tgt_drive = tgt_drive;
        next_fire = 1'b0;
        if (start_det) begin
            // a start, repeated or not, always reopens addressing
            next_state = S_ADDR;
            next_bitcnt = 4'h0;
            next_tgt_drive = 1'b0;
        end else if (stop_det) begin
            // stop releases the bus and applies a pending byte
            next_state = S_IDLE;
            next_tgt_drive = 1'b0;
            next_fire = pend;
            next_pend = 1'b0;
        end else begin
            case (state)
                S_ADDR: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda};
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        if (addr_hit) begin
                            next_state = S_ADDR_ACK;
                            next_tgt_drive = 1'b1;
                            next_rw = shreg[0];
                        end else begin
                            next_state = S_IDLE;
                        end
                    end
                end
                S_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_bitcnt = 4'h0;
                        if (rw) begin
                            // interrupt states are captured here, at the read
                            next_state = S_READ;
                            next_txreg = read_byte;
                            next_tgt_drive = ~read_byte[7];
                        end else begin
                            next_state = S_WRITE;
                            next_tgt_drive = 1'b0;
                        end
                    end
                end
                S_WRITE: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda};
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        // every complete byte overwrites the last
                        next_ctrl = sh_low;
                        next_pend = 1'b1;
                        next_state = S_WR_ACK;
                        next_tgt_drive = 1'b1;
                    end
                end
                S_WR_ACK: begin
                    if (scl_fall) begin
                        next_state = S_WRITE;
                        next_bitcnt = 4'h0;
                        next_tgt_drive = 1'b0;
                    end
                end
                S_READ: begin
                    if (scl_rise) begin
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (byte_done) begin
                            next_state = S_RD_ACK;
                            next_tgt_drive = 1'b0;
                        end else begin
                            next_txreg = {txreg[6:0], 1'b0};
                            next_tgt_drive = ~txreg[6];
                        end
                    end
                end
                S_RD_ACK: begin
                    if (scl_rise) begin
                        next_nack = sda;
                    end else if (scl_fall) begin
                        if (nack) begin
                            // master is done; stay off the bus until a start
                            next_state = S_IDLE;
                        end else begin
                            next_state = S_READ;
                            next_bitcnt = 4'h0;
                            next_txreg = read_byte;
                            next_tgt_drive = ~read_byte[7];
                        end
                    end
                end
                default: begin
                    next_state = S_IDLE;
                end
            endcase
        end
    end

    // link registers; reset loads S_IDLE, sets scl_q and sda_q high and zeroes the rest
    always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state <= S_IDLE;
            bitcnt <= 4'h0;
            shreg <= CTRL_RESET;
            txreg <= CTRL_RESET;
            ctrl <= CTRL_LOW_RESET;
            rw <= 1'b0;
            nack <= 1'b0;
            pend <= 1'b0;
            tgt_drive <= 1'b0;
            fire <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            state <= next_state;
            bitcnt <= next_bitcnt;
            shreg <= next_shreg;
            txreg <= next_txreg;
            ctrl <= next_ctrl;
            rw <= next_rw;
            nack <= next_nack;
            pend <= next_pend;
            tgt_drive <= next_tgt_drive;
            fire <= next_fire;
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    // ---------------- system domain ----------------

    logic apply_valid; // byte arrived after a stop
    logic [3:0] apply_word; // control bits to apply
    logic [1:0] up_s; // synced {data, clock}
    logic [3:0] dn_clk_s, dn_dat_s; // synced channel lines
    logic [3:0] irq_s; // synced interrupt inputs
    logic tgt_drive_s; // target pull, seen in this domain
    wire tgt_drive_n_link = ~tgt_drive; // idle-high form so reset reads as released
    wire [10:0] line_s; // synced lines, see the slices below

    // only the stop-qualified event moves the selection
    fcim_word_xfer #(.WIDTH(4)) u_apply_xfer (
        .src_clk(LINK_CLK),
        .src_rst_n(link_rst_n),
        .src_fire(fire),
        .src_word(ctrl),
        .dst_clk(SYS_CLK),
        .dst_rst_n(RESET_N),
        .dst_valid(apply_valid),
        .dst_word(apply_word)
    );

    fcim_sync #(.WIDTH(11), .RESET_VAL(11'h7ff)) u_line_sync (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .d({tgt_drive_n_link, UP_DAT_IN, UP_CLK_IN,
            DOWN_DAT_3_IN, DOWN_DAT_2_IN, DOWN_DAT_1_IN, DOWN_DAT_0_IN,
            DOWN_CLK_3_IN, DOWN_CLK_2_IN, DOWN_CLK_1_IN, DOWN_CLK_0_IN}),
        .q(line_s)
    );

    fcim_sync #(.WIDTH(4), .RESET_VAL(4'hf)) u_irq_sync (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .d({IRQ_IN_N_3, IRQ_IN_N_2, IRQ_IN_N_1, IRQ_IN_N_0}),
        .q(irq_s)
    );

    assign dn_clk_s = line_s[3:0];
    assign dn_dat_s = line_s[7:4];
    assign up_s = line_s[9:8];
    assign tgt_drive_s = ~line_s[10];

    logic sel_en; // a channel is enabled
    logic [1:0] sel_idx; // which one
    logic [2:0] blank [0:9]; // hold-off per driven line
    logic [9:0] fwd; // pass-through pulls: 3:0 clk, 7:4 dat, 8 up clk, 9 up dat
    logic out_low; // level put on every line we pull

    wire [3:0] chan_sel = fcim_decode(sel_en, sel_idx);
    wire [9:0] blanked;
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++) begin : g_blank
            assign blanked[gi] = (blank[gi] != 3'h0);
        end
    endgenerate

    // a line we just let go still reads low for a few cycles through the
    // synchroniser; without the hold-off it would latch the pair low
    wire up_clk_low = ~up_s[0] & ~blanked[8];
    wire up_dat_low = ~up_s[1] & ~blanked[9];
    wire [3:0] dn_clk_low = ~dn_clk_s & ~blanked[3:0];
    wire [3:0] dn_dat_low = ~dn_dat_s & ~blanked[7:4];
    wire [9:0] next_fwd = {
        |(chan_sel & dn_dat_low),
        |(chan_sel & dn_clk_low),
        chan_sel & {4{up_dat_low}},
        chan_sel & {4{up_clk_low}}
    };

    // selection register; reset leaves every channel disconnected
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sel_en <= 1'b0;
            sel_idx <= 2'h0;
        end else if (apply_valid) begin
            sel_en <= apply_word[CTRL_EN_POS];
            sel_idx <= apply_word[CTRL_IDX_LSB +: 2];
        end
    end

    // hold-off timers reload while a line is pulled
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < 10; i++) begin
                blank[i] <= 3'h0;
            end
        end else begin
            for (int i = 0; i < 10; i++) begin
                if (fwd[i]) begin
                    blank[i] <= BLANK_CYC;
                end else if (blanked[i]) begin
                    blank[i] <= blank[i] - 3'h1;
                end
            end
        end
    end

    // pin drivers, all from flops
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            fwd <= 10'h000;
            out_low <= 1'b0;
            UP_CLK_OE <= 1'b0;
            UP_DAT_OE <= 1'b0;
            IRQ_OUT_N <= 1'b1;
        end else begin
            fwd <= next_fwd;
            out_low <= 1'b0;
            UP_CLK_OE <= next_fwd[8];
            UP_DAT_OE <= next_fwd[9] | tgt_drive_s;
            IRQ_OUT_N <= &irq_s;
        end
    end

    // open-drain lines only ever drive low
    assign UP_CLK_OUT = out_low;
    assign UP_DAT_OUT = out_low;
    assign {DOWN_CLK_3_OUT, DOWN_CLK_2_OUT, DOWN_CLK_1_OUT, DOWN_CLK_0_OUT} = {4{out_low}};
    assign {DOWN_DAT_3_OUT, DOWN_DAT_2_OUT, DOWN_DAT_1_OUT, DOWN_DAT_0_OUT} = {4{out_low}};
    assign {DOWN_CLK_3_OE, DOWN_CLK_2_OE, DOWN_CLK_1_OE, DOWN_CLK_0_OE} = fwd[3:0];
    assign {DOWN_DAT_3_OE, DOWN_DAT_2_OE, DOWN_DAT_1_OE, DOWN_DAT_0_OE} = fwd[7:4];

    // ---------------- checks ----------------

    sequence seq_addr_done;
        state == S_ADDR && scl_fall && byte_done && !start_det && !stop_det;
    endsequence

    sequence seq_write_done;
        state == S_WRITE && scl_fall && byte_done && !start_det && !stop_det;
    endsequence

    a_addr_ack_match: assert property (@(posedge LINK_CLK) disable iff (!link_rst_n)
        seq_addr_done and addr_hit |=> state == S_ADDR_ACK && tgt_drive)
        else $error("matching address not acknowledged");

    a_addr_miss_idle: assert property (@(posedge LINK_CLK) disable iff (!link_rst_n)
        seq_addr_done and !addr_hit |=> state == S_IDLE && !tgt_drive)
        else $error("foreign address not ignored");

    a_rw_direction: assert property (@(posedge LINK_CLK) disable iff (!link_rst_n)
        state == S_ADDR_ACK && scl_fall && !start_det && !stop_det
        |=> state == (rw ? S_READ : S_WRITE))
        else $error("direction bit not honoured");

    a_write_store: assert property (@(posedge LINK_CLK) disable iff (!link_rst_n)
        seq_write_done |=> ctrl == $past(sh_low) && pend && tgt_drive)
        else $error("written byte not stored");

    a_last_byte: assert property (@(posedge LINK_CLK) disable iff (!link_rst_n)
        state == S_WR_ACK |-> ctrl == sh_low)
        else $error("control does not hold the last byte");

    a_read_first_bit: assert property (@(posedge LINK_CLK) disable iff (!link_rst_n)
        state == S_ADDR_ACK && rw && scl_fall && !start_det && !stop_det
        |=> txreg == $past(read_byte) && tgt_drive == !txreg[7])
        else $error("read byte not loaded");

    a_stop_fires: assert property (@(posedge LINK_CLK) disable iff (!link_rst_n)
        stop_det && pend |=> fire ##1 !fire && !pend)
        else $error("stop did not apply the byte");

    a_one_channel: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        $onehot0(fwd[3:0]) && $onehot0(fwd[7:4]))
        else $error("more than one channel driven");

    a_select_on_event: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        $changed(chan_sel) |-> $past(apply_valid))
        else $error("channel changed without a stop");

    a_disable_none: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        apply_valid && !apply_word[CTRL_EN_POS] |=> chan_sel == 4'h0 ##1 fwd == 10'h000)
        else $error("cleared enable left a channel on");

    a_irq_and: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        irq_s != 4'hf |=> !IRQ_OUT_N)
        else $error("interrupt output not low");

endmodule

// ---- rtl/fcim_pkg.sv ----
package fcim_pkg;

    // clock rates
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int SCL_MAX_HZ = 400_000;
    localparam int SYS_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;

    // target address: fixed upper bits, pin-set lower bits
    localparam logic [3:0] ADDR_FIXED = 4'he;

    // control byte layout
    localparam int CTRL_IDX_LSB = 0;
    localparam int CTRL_EN_POS = 2;
    localparam int CTRL_IRQ_LSB = 4;
    localparam logic [3:0] CTRL_LOW_RESET = 4'h0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // serial framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // after a pass-through driver lets go, ignore the low it leaves behind
    localparam int BLANK_NS = 150;
    localparam int BLANK_CYC_I = (BLANK_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam logic [2:0] BLANK_CYC = 3'(BLANK_CYC_I);

    // bus target states, one-hot
    typedef enum logic [6:0] {
        S_IDLE     = 7'h01,
        S_ADDR     = 7'h02,
        S_ADDR_ACK = 7'h04,
        S_WRITE    = 7'h08,
        S_WR_ACK   = 7'h10,
        S_READ     = 7'h20,
        S_RD_ACK   = 7'h40
    } fcim_state_t;

    // enable bit plus index to a one-hot channel vector
    function automatic logic [3:0] fcim_decode(input logic en, input logic [1:0] idx);
        return en ? (4'h1 << idx) : 4'h0;
    endfunction

endpackage

// ---- rtl/fcim_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser; only the second stage is visible
module fcim_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset of the receiving domain
    input wire logic clk,
    input wire logic rst_n,
    // asynchronous level in, synchronised level out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta; // first stage, read by q only

    // both stages reset to the idle level of the line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ---- rtl/fcim_word_xfer.sv ----
`timescale 1ns/1ps
// carries one word plus an event across domains with a toggle
module fcim_word_xfer #(
    parameter int WIDTH = 8
) (
    // source domain
    input wire logic src_clk,
    input wire logic src_rst_n,
    input wire logic src_fire,
    input wire logic [WIDTH-1:0] src_word,
    // destination domain
    input wire logic dst_clk,
    input wire logic dst_rst_n,
    output logic dst_valid,
    output logic [WIDTH-1:0] dst_word
);
    logic [WIDTH-1:0] hold; // word frozen until the next event
    logic tgl; // flips once per event
    logic tgl_s; // toggle seen in destination
    logic tgl_q; // previous toggle for edge detect
    wire seen = tgl_s ^ tgl_q;

    // source side: freeze the word and flip the toggle on the same edge
    always_ff @(posedge src_clk or negedge src_rst_n) begin
        if (!src_rst_n) begin
            hold <= '0;
            tgl <= 1'b0;
        end else if (src_fire) begin
            hold <= src_word;
            tgl <= ~tgl;
        end
    end

    fcim_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_tgl_sync (
        .clk(dst_clk),
        .rst_n(dst_rst_n),
        .d(tgl),
        .q(tgl_s)
    );

    // destination side: hold has been stable for two edges when seen
    always_ff @(posedge dst_clk or negedge dst_rst_n) begin
        if (!dst_rst_n) begin
            tgl_q <= 1'b0;
            dst_valid <= 1'b0;
            dst_word <= '0;
        end else begin
            tgl_q <= tgl_s;
            dst_valid <= seen;
            if (seen) begin
                dst_word <= hold;
            end
        end
    end
endmodule

// ---- tb/fcim_master.sv ----
`timescale 1ns/1ps
// upstream bus master; it only pulls lines low, bench pull-ups raise them
module fcim_master (
    // resolved lines
    input wire logic scl,
    input wire logic sda,
    // pull-low drives
    output logic scl_low,
    output logic sda_low
);
    localparam int Q = 1500; // quarter bit: high and low stay above 1 us
    initial begin
        scl_low = 0;
        sda_low = 0;
    end
    // one bit; data moves only while the clock is low
    task automatic bit_io(input logic b, output logic got);
        sda_low = ~b;
        #Q;
        scl_low = 0;
        #Q;
        got = sda;
        #Q;
        scl_low = 1;
        #Q;
    endtask
    // eight bits msb first, then the ninth (acknowledge) bit
    task automatic xbyte(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
                         output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(nine, ack);
        ack = ~ack;
    endtask
    // start, then address with direction bit
    task automatic start(input logic [6:0] adr, input logic rd, output logic ack);
        logic [7:0] rx;
        sda_low = 0;
        #Q;
        scl_low = 0;
        #Q;
        sda_low = 1;
        #Q;
        scl_low = 1;
        #Q;
        xbyte({adr, rd}, 1'b1, rx, ack);
    endtask
    // stop: data rises while clock high; clock then stands high
    task automatic stop();
        sda_low = 1;
        #Q;
        scl_low = 0;
        #Q;
        sda_low = 0;
        #Q;
    endtask
endmodule

// ---- tb/fcim_mux_ctrl_tb_top.sv ----
`timescale 1ns/1ps
// bench: master upstream, pull-ups and a pulling device downstream
module fcim_mux_ctrl_tb_top;
    import fcim_pkg::*;
    logic sys_clk = 0, reset_n = 0, link_clk = 0, a;
    logic [2:0] pins = 0;
    logic [3:0] irq_n = 4'hf, dev_low = 4'h0;
    logic [7:0] exp_q[$], seen_q[$], cur, d, rx;
    string nm_q[$];
    int num_errors = 0, cmp_count = 0, cyc = 0;
    wire ms_cl, ms_dl, up_cl, up_dl, irq_o;
    wire [3:0] dc_oe, dd_oe;
    wire [3:0] dc_in = ~(dc_oe | dev_low);
    wire [3:0] dd_in = ~dd_oe;
    // open-drain wires with pull-ups
    wire scl = ~(ms_cl | up_cl);
    wire sda = ~(ms_dl | up_dl);
    always #25 sys_clk = ~sys_clk;
    // link clock, phase unrelated to the system clock
    initial begin
        #17;
        forever #62.5 link_clk = ~link_clk;
    end
    fcim_mux_ctrl fcim_mux_ctrl_i (
        .SYS_CLK(sys_clk), .RESET_N(reset_n), .LINK_CLK(link_clk),
        .ADDR_PIN_0(pins[0]), .ADDR_PIN_1(pins[1]), .ADDR_PIN_2(pins[2]),
        .UP_CLK_IN(scl), .UP_CLK_OUT(), .UP_CLK_OE(up_cl),
        .UP_DAT_IN(sda), .UP_DAT_OUT(), .UP_DAT_OE(up_dl),
        .DOWN_CLK_0_IN(dc_in[0]), .DOWN_CLK_0_OUT(), .DOWN_CLK_0_OE(dc_oe[0]),
        .DOWN_DAT_0_IN(dd_in[0]), .DOWN_DAT_0_OUT(), .DOWN_DAT_0_OE(dd_oe[0]),
        .DOWN_CLK_1_IN(dc_in[1]), .DOWN_CLK_1_OUT(), .DOWN_CLK_1_OE(dc_oe[1]),
        .DOWN_DAT_1_IN(dd_in[1]), .DOWN_DAT_1_OUT(), .DOWN_DAT_1_OE(dd_oe[1]),
        .DOWN_CLK_2_IN(dc_in[2]), .DOWN_CLK_2_OUT(), .DOWN_CLK_2_OE(dc_oe[2]),
        .DOWN_DAT_2_IN(dd_in[2]), .DOWN_DAT_2_OUT(), .DOWN_DAT_2_OE(dd_oe[2]),
        .DOWN_CLK_3_IN(dc_in[3]), .DOWN_CLK_3_OUT(), .DOWN_CLK_3_OE(dc_oe[3]),
        .DOWN_DAT_3_IN(dd_in[3]), .DOWN_DAT_3_OUT(), .DOWN_DAT_3_OE(dd_oe[3]),
        .IRQ_IN_N_0(irq_n[0]), .IRQ_IN_N_1(irq_n[1]), .IRQ_IN_N_2(irq_n[2]),
        .IRQ_IN_N_3(irq_n[3]), .IRQ_OUT_N(irq_o)
    );
    fcim_master fcim_master_i (.scl(scl), .sda(sda), .scl_low(ms_cl), .sda_low(ms_dl));
    // compare one result with its note
    task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic note(input string nm, input logic [7:0] e);
        nm_q.push_back(nm);
        exp_q.push_back(e);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // watcher takes the oldest note for every result seen; also cuts a hang
    always @(posedge sys_clk) begin
        cyc++;
        while (seen_q.size() > 0) begin
            check(nm_q.pop_front(), seen_q.pop_front(), exp_q.pop_front());
        end
        if (cyc == 60000) begin
            num_errors++;
            wrap_up();
        end
    end
    // read back; clock held low after the address shows the live channel
    task automatic rd_chk(input logic [3:0] lo);
        fcim_master_i.start({ADDR_FIXED, pins}, 1'b1, a);
        note("sel", cur);
        seen_q.push_back({4'h0, dc_oe});
        // first read bit is low when channel 3 is quiet; it reaches the live channel
        note("dat", irq_n[3] ? cur : 8'h0);
        seen_q.push_back({4'h0, dd_oe});
        fcim_master_i.xbyte(8'hff, 1'b1, rx, a);
        note("read", {~irq_n, lo});
        seen_q.push_back(rx);
        fcim_master_i.stop();
    endtask
    initial begin
        void'($urandom(25));
        repeat (4) @(posedge sys_clk);
        #2;
        reset_n = 1;
        pins = 3'($urandom);
        irq_n = 4'($urandom);
        cur = 8'h0;
        repeat (40) @(posedge sys_clk);
        #2;
        rd_chk(4'h0);
        $display("test reset done");
        // four channels then disable; two bytes, only the last must count
        for (int k = 0; k < 5; k++) begin
            d = {4'($urandom), 1'($urandom), 1'(k < 4), 2'(k)};
            @(posedge sys_clk);
            #2;
            irq_n = 4'($urandom);
            fcim_master_i.start({ADDR_FIXED, pins}, 1'b0, a);
            note("ack", 8'h1);
            seen_q.push_back({7'h0, a});
            fcim_master_i.xbyte(8'($urandom), 1'b1, rx, a);
            fcim_master_i.xbyte(d, 1'b1, rx, a);
            note("hold", cur);
            seen_q.push_back({4'h0, dc_oe});
            fcim_master_i.stop();
            cur = (k < 4) ? 8'h1 << k : 8'h0;
            rd_chk(d[3:0]);
            // downstream lows reach upstream only through a live channel
            @(posedge sys_clk);
            #2;
            dev_low = 4'hf;
            repeat (20) @(posedge sys_clk);
            #2;
            note("up", {7'h0, 1'(k < 4)});
            seen_q.push_back({7'h0, up_cl});
            note("irq", {7'h0, &irq_n});
            seen_q.push_back({7'h0, irq_o});
            dev_low = 4'h0;
            repeat (20) @(posedge sys_clk);
            #2;
            $display("test %0d done", k);
        end
        // foreign addresses: no ack, data not stored
        for (int j = 0; j < 2; j++) begin
            fcim_master_i.start(j ? {4'h6, pins} : {ADDR_FIXED, ~pins}, 1'b0, a);
            note("nack", 8'h0);
            seen_q.push_back({7'h0, a});
            fcim_master_i.xbyte(8'h04, 1'b1, rx, a);
            fcim_master_i.stop();
            rd_chk(d[3:0]);
            $display("test foreign %0d done", j);
        end
        @(posedge sys_clk);
        #2;
        wrap_up();
    end
endmodule
